//--- shared/amr_consts.vh
// register offsets, codes and field constants for the actuator register map
`ifndef AMR_CONSTS_VH
`define AMR_CONSTS_VH
`define AMR_REG_DEMAND 16'h0000
`define AMR_REG_DIAG_RST 16'h0001
`define AMR_REG_RECAL 16'h0002
`define AMR_REG_CAL_LO 16'h0003
`define AMR_REG_CAL_HI 16'h0004
`define AMR_REG_RSVD_A 16'h0005
`define AMR_REG_RSVD_B 16'h0006
`define AMR_REG_RSVD_C 16'h0007
`define AMR_REG_TEST 16'h0008
`define AMR_REG_MEAS_POS 16'h0009
`define AMR_REG_APPLIED 16'h000a
`define AMR_REG_LIVE 16'h000b
`define AMR_REG_MOVES 16'h000c
`define AMR_REG_POWERED 16'h000e
`define AMR_REG_OPEN 16'h0010
`define AMR_REG_CLOSED 16'h0012
`define AMR_REG_POWERUPS 16'h0014
`define AMR_REG_SERIAL 16'h0016
`define AMR_REG_ANALOG 16'h0018
`define AMR_REG_FW_PROJ 16'h0019
`define AMR_REG_FW_DOC 16'h001a
`define AMR_REG_FW_REL 16'h001b
`define AMR_REG_STICKY 16'h001c
`define AMR_REG_RSVD_D 16'h001d
`define AMR_TEST_PATTERN 16'hb38c
`define AMR_PCT_MAX 16'h0064
`define AMR_ZERO16 16'h0000
`define AMR_ONE16 16'h0001
`define AMR_FN_READ 8'h03
`define AMR_FN_WRITE1 8'h06
`define AMR_FN_WRITEN 8'h10
`define AMR_EXC_FUNC 8'h01
`define AMR_EXC_ADDR 8'h02
`define AMR_EXC_VALUE 8'h03
`define AMR_EXC_NONE 8'h00
`define AMR_ANALOG_MAX_V 16'h0032
`define AMR_ANALOG_MAX_I 16'h00c8
`endif

//--- hw/amr_register_map.v
// holding-register bank of the electric valve actuator
//
// Summary of operation
// - position demand word 0-100% writable; measured position read-only.
// - writing one to diagnostic reset clears diagnostic state; zero idle.
// - writing one to recalibrate drops calibration, awaits new sequence.
// - writing one to low-point word captures analog input as zero point.
// - writing one to high-point word captures analog input as full scale.
// - reserved words are read-only and always return zero.
// - test word always returns fixed pattern 45964 decimal.
// - applied demand word reports demand from the active control source.
// - live fault flags word shows present diagnostic bits.
// - sticky fault word accumulates every flag ever set, kept persistent.
// - powered-time counter 32-bit, low word at lower address.
// - open-time counter 32-bit, low word first, counts at 100%.
// - closed-time counter 32-bit, low word first, counts at 0%.
// - power-up counter 32-bit, increments once per successful power-up.
// - analog reading scaled ten counts per unit, 0-50 or 0-200.
// - firmware version word: major in upper byte, minor in lower.
`timescale 1ns/100ps
`include "amr_consts.vh"

module amr_register_map #(
  parameter [15:0] fw_project = 16'h0001,  // arbitrary value
  parameter [15:0] fw_docref = 16'h0001,   // arbitrary value
  parameter [15:0] fw_release = 16'h0100,  // arbitrary value
  parameter [31:0] serial_default = 32'h0000_0001, // arbitrary value
  parameter [15:0] time_tick_cycles = 16'h0010
)(
  input wire ref_clk,
  input wire rst,
  // request from the modbus frame engine, one word per strobe
  input wire req_valid,
  input wire [7:0] req_func,
  input wire [15:0] req_addr,
  input wire [15:0] req_wdata,
  output reg rsp_valid,
  output reg [15:0] rsp_rdata,
  output reg rsp_exception,
  output reg [7:0] rsp_exc_code,
  // actuator side
  input wire [15:0] position_meas,
  input wire [15:0] local_demand,
  input wire local_source_sel,
  input wire [15:0] fault_flags_in,
  input wire [15:0] analog_level,
  input wire analog_current_mode,
  input wire move_done,
  input wire powerup_ok,
  input wire [15:0] sticky_restore,
  input wire [31:0] moves_restore,
  input wire [31:0] powered_restore,
  input wire [31:0] open_restore,
  input wire [31:0] closed_restore,
  input wire [31:0] powerups_restore,
  input wire restore_load,
  output reg [15:0] position_demand,
  output reg [15:0] applied_demand,
  output reg diag_clear_pulse,
  output reg recal_pulse,
  output reg calibrated,
  output reg [15:0] cal_zero_level,
  output reg [15:0] cal_full_level,
  output reg [15:0] sticky_fault_flags,
  output reg [31:0] movement_count,
  output reg [31:0] powered_time,
  output reg [31:0] open_time,
  output reg [31:0] closed_time,
  output reg [31:0] power_on_count
);

  reg [15:0] diagnostic_reset;
  reg [15:0] recalibrate_request;
  reg [15:0] cal_low_point;
  reg [15:0] cal_high_point;
  reg [15:0] tick_cnt;
  reg [15:0] analog_scaled;
  reg [15:0] rd_word;
  reg rd_ok;
  reg wr_ok;
  reg [15:0] next_rsp_rdata;
  reg next_rsp_exception;
  reg [7:0] next_rsp_exc_code;
  wire tick;
  wire is_read;
  wire is_write;

  function [15:0] clamp_pct;
    input [15:0] v;
    begin
      clamp_pct = (v > `AMR_PCT_MAX) ? `AMR_PCT_MAX : v;
    end
  endfunction

  function [15:0] word_of;
    input [31:0] v;
    input hi;
    begin
      word_of = hi ? v[31:16] : v[15:0];
    end
  endfunction

  assign is_read = (req_func == `AMR_FN_READ);
  assign is_write = (req_func == `AMR_FN_WRITE1) ||
                    (req_func == `AMR_FN_WRITEN);
  // slow time base for the life counters; real units come from the divider
  assign tick = (tick_cnt == time_tick_cycles - 16'h0001);

  // analog reading saturates at the full scale of the selected mode
  always @*
  begin
    analog_scaled = analog_level;
    if (analog_current_mode)
    begin
      if (analog_level > `AMR_ANALOG_MAX_I)
        analog_scaled = `AMR_ANALOG_MAX_I;
    end
    else
    begin
      if (analog_level > `AMR_ANALOG_MAX_V)
        analog_scaled = `AMR_ANALOG_MAX_V;
    end
  end

  // read decode; the 32-bit counters hand out low word at even address
  always @*
  begin
    rd_ok = 1'b1;
    rd_word = `AMR_ZERO16;
    case (req_addr)
      `AMR_REG_DEMAND: rd_word = position_demand;
      `AMR_REG_DIAG_RST: rd_word = diagnostic_reset;
      `AMR_REG_RECAL: rd_word = recalibrate_request;
      `AMR_REG_CAL_LO: rd_word = cal_low_point;
      `AMR_REG_CAL_HI: rd_word = cal_high_point;
      `AMR_REG_RSVD_A, `AMR_REG_RSVD_B, `AMR_REG_RSVD_C,
      `AMR_REG_RSVD_D: rd_word = `AMR_ZERO16;
      `AMR_REG_TEST: rd_word = `AMR_TEST_PATTERN;
      `AMR_REG_MEAS_POS: rd_word = clamp_pct(position_meas);
      `AMR_REG_APPLIED: rd_word = applied_demand;
      `AMR_REG_LIVE: rd_word = fault_flags_in;
      `AMR_REG_MOVES, `AMR_REG_MOVES + 16'h0001:
        rd_word = word_of(movement_count, req_addr[0]);
      `AMR_REG_POWERED, `AMR_REG_POWERED + 16'h0001:
        rd_word = word_of(powered_time, req_addr[0]);
      `AMR_REG_OPEN, `AMR_REG_OPEN + 16'h0001:
        rd_word = word_of(open_time, req_addr[0]);
      `AMR_REG_CLOSED, `AMR_REG_CLOSED + 16'h0001:
        rd_word = word_of(closed_time, req_addr[0]);
      `AMR_REG_POWERUPS, `AMR_REG_POWERUPS + 16'h0001:
        rd_word = word_of(power_on_count, req_addr[0]);
      `AMR_REG_SERIAL, `AMR_REG_SERIAL + 16'h0001:
        rd_word = word_of(serial_default, req_addr[0]);
      `AMR_REG_ANALOG: rd_word = analog_scaled;
      `AMR_REG_FW_PROJ: rd_word = fw_project;
      `AMR_REG_FW_DOC: rd_word = fw_docref;
      `AMR_REG_FW_REL: rd_word = fw_release;
      `AMR_REG_STICKY: rd_word = sticky_fault_flags;
      default: rd_ok = 1'b0;
    endcase
  end

  // only the five command words accept writes
  always @*
  begin
    case (req_addr)
      `AMR_REG_DEMAND, `AMR_REG_DIAG_RST, `AMR_REG_RECAL,
      `AMR_REG_CAL_LO, `AMR_REG_CAL_HI: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // response decode, registered below
  always @*
  begin
    next_rsp_rdata = `AMR_ZERO16;
    next_rsp_exception = 1'b0;
    next_rsp_exc_code = `AMR_EXC_NONE;
    if (req_valid)
    begin
      if (!is_read && !is_write)
      begin
        next_rsp_exception = 1'b1;
        next_rsp_exc_code = `AMR_EXC_FUNC;
      end
      else if (is_read && rd_ok)
        next_rsp_rdata = rd_word;
      else if (is_write && wr_ok && req_addr == `AMR_REG_DEMAND &&
               req_wdata > `AMR_PCT_MAX)
      begin
        next_rsp_exception = 1'b1;
        next_rsp_exc_code = `AMR_EXC_VALUE;
      end
      else if (!(is_write && wr_ok))
      begin
        next_rsp_exception = 1'b1;
        next_rsp_exc_code = `AMR_EXC_ADDR;
      end
    end
  end

  // response path
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= `AMR_ZERO16;
      rsp_exception <= 1'b0;
      rsp_exc_code <= `AMR_EXC_NONE;
    end
    else
    begin
      rsp_valid <= req_valid;
      rsp_rdata <= next_rsp_rdata;
      rsp_exception <= next_rsp_exception;
      rsp_exc_code <= next_rsp_exc_code;
    end
  end

  // command words; reset and recal triggers fire a pulse, calibration triggers capture; all self-clear a cycle later
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      position_demand <= `AMR_ZERO16;
      diagnostic_reset <= `AMR_ZERO16;
      recalibrate_request <= `AMR_ZERO16;
      cal_low_point <= `AMR_ZERO16;
      cal_high_point <= `AMR_ZERO16;
      diag_clear_pulse <= 1'b0;
      recal_pulse <= 1'b0;
      calibrated <= 1'b0;
      cal_zero_level <= `AMR_ZERO16;
      cal_full_level <= `AMR_ZERO16;
    end
    else
    begin
      diag_clear_pulse <= 1'b0;
      recal_pulse <= 1'b0;
      // any nonzero value is cleared; only a one starts the action
      if (diagnostic_reset != `AMR_ZERO16)
      begin
        diag_clear_pulse <= (diagnostic_reset == `AMR_ONE16);
        diagnostic_reset <= `AMR_ZERO16;
      end
      if (recalibrate_request != `AMR_ZERO16)
      begin
        if (recalibrate_request == `AMR_ONE16)
        begin
          recal_pulse <= 1'b1;
          calibrated <= 1'b0;
        end
        recalibrate_request <= `AMR_ZERO16;
      end
      if (cal_low_point != `AMR_ZERO16)
      begin
        if (cal_low_point == `AMR_ONE16)
          cal_zero_level <= analog_scaled;
        cal_low_point <= `AMR_ZERO16;
      end
      if (cal_high_point != `AMR_ZERO16)
      begin
        if (cal_high_point == `AMR_ONE16)
        begin
          cal_full_level <= analog_scaled;
          calibrated <= 1'b1;
        end
        cal_high_point <= `AMR_ZERO16;
      end
      if (req_valid && is_write && wr_ok)
      begin
        case (req_addr)
          `AMR_REG_DEMAND:
            if (req_wdata <= `AMR_PCT_MAX)
              position_demand <= req_wdata;
          `AMR_REG_DIAG_RST: diagnostic_reset <= req_wdata;
          `AMR_REG_RECAL: recalibrate_request <= req_wdata;
          `AMR_REG_CAL_LO: cal_low_point <= req_wdata;
          `AMR_REG_CAL_HI: cal_high_point <= req_wdata;
          default: position_demand <= position_demand;
        endcase
      end
    end
  end

  // applied demand follows whichever source is selected
  always @(posedge ref_clk)
  begin
    if (rst)
      applied_demand <= `AMR_ZERO16;
    else if (local_source_sel)
      applied_demand <= clamp_pct(local_demand);
    else
      applied_demand <= position_demand;
  end

  // time base for the life counters; a restore restarts it so the
  // first tick after a reload is a whole period
  always @(posedge ref_clk)
  begin
    if (rst || restore_load)
      tick_cnt <= `AMR_ZERO16;
    else if (tick)
      tick_cnt <= `AMR_ZERO16;
    else
      tick_cnt <= tick_cnt + 16'h0001;
  end

  // history and life counters; restore_load reloads them from
  // non-volatile storage, since reset alone would lose them
  // new faults are or-ed in; diagnostic reset never wipes history
  always @(posedge ref_clk)
  begin
    if (rst)
      sticky_fault_flags <= `AMR_ZERO16;
    else if (restore_load)
      sticky_fault_flags <= sticky_restore;
    else
      sticky_fault_flags <= sticky_fault_flags | fault_flags_in;
  end

  always @(posedge ref_clk)
  begin
    if (rst)
      movement_count <= 32'h0000_0000;
    else if (restore_load)
      movement_count <= moves_restore;
    else if (move_done)
      movement_count <= movement_count + 32'h0000_0001;
  end

  always @(posedge ref_clk)
  begin
    if (rst)
      power_on_count <= 32'h0000_0000;
    else if (restore_load)
      power_on_count <= powerups_restore;
    else if (powerup_ok)
      power_on_count <= power_on_count + 32'h0000_0001;
  end

  always @(posedge ref_clk)
  begin
    if (rst)
      powered_time <= 32'h0000_0000;
    else if (restore_load)
      powered_time <= powered_restore;
    else if (tick)
      powered_time <= powered_time + 32'h0000_0001;
  end

  always @(posedge ref_clk)
  begin
    if (rst)
      open_time <= 32'h0000_0000;
    else if (restore_load)
      open_time <= open_restore;
    else if (tick && position_meas >= `AMR_PCT_MAX)
      open_time <= open_time + 32'h0000_0001;
  end

  always @(posedge ref_clk)
  begin
    if (rst)
      closed_time <= 32'h0000_0000;
    else if (restore_load)
      closed_time <= closed_restore;
    else if (tick && position_meas == `AMR_ZERO16)
      closed_time <= closed_time + 32'h0000_0001;
  end

endmodule

//--- verification/amr_plant_model.sv
// valve and motor model that follows the position demand
`timescale 1ns/100ps
module amr_plant_model (
  input wire ref_clk,
  input wire rst,
  input wire [15:0] position_demand,
  output reg [15:0] position_meas,
  output reg move_done
);
  // one percent per cycle keeps moves short but still many cycles long
  always @(posedge ref_clk)
  begin
    move_done <= 1'b0;
    if (rst)
      position_meas <= 16'h0000;
    else if (position_meas < position_demand)
    begin
      position_meas <= position_meas + 16'h0001;
      move_done <= position_meas + 16'h0001 == position_demand;
    end
    else if (position_meas > position_demand)
    begin
      position_meas <= position_meas - 16'h0001;
      move_done <= position_meas - 16'h0001 == position_demand;
    end
  end
endmodule

//--- verification/amr_map_sva.sv
// port checks of the register map
`timescale 1ns/100ps
`include "amr_consts.vh"
module amr_map_sva (
  input wire ref_clk,
  input wire rst,
  input wire req_valid,
  input wire [7:0] req_func,
  input wire [15:0] req_addr,
  input wire [15:0] req_wdata,
  input wire rsp_valid,
  input wire [15:0] rsp_rdata,
  input wire rsp_exception,
  input wire [7:0] rsp_exc_code,
  input wire [15:0] position_demand,
  input wire diag_clear_pulse,
  input wire recal_pulse
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire rd_req = req_valid && req_func == `AMR_FN_READ;
  wire wr_req = req_valid && (req_func == `AMR_FN_WRITE1 ||
    req_func == `AMR_FN_WRITEN);
  wire dem_wr = wr_req && req_addr == `AMR_REG_DEMAND;
  ans_timing_a: assert property (req_valid |=> rsp_valid)
    else $error("no answer one cycle after request");
  test_word_a: assert property (rd_req && req_addr == `AMR_REG_TEST
    |=> rsp_rdata == `AMR_TEST_PATTERN && !rsp_exception)
    else $error("test word wrong");
  rsvd_zero_a: assert property (rd_req && req_addr >= `AMR_REG_RSVD_A
    && req_addr <= `AMR_REG_RSVD_C |=> rsp_rdata == 16'h0000)
    else $error("reserved word not zero");
  ro_refuse_a: assert property (wr_req && req_addr > `AMR_REG_CAL_HI
    && req_addr <= `AMR_REG_RSVD_D
    |=> rsp_exception && rsp_exc_code == `AMR_EXC_ADDR)
    else $error("read-only write accepted");
  bad_func_a: assert property (req_valid && !rd_req && !wr_req
    |=> rsp_exception && rsp_exc_code == `AMR_EXC_FUNC)
    else $error("bad function accepted");
  demand_limit_a: assert property (dem_wr && req_wdata > `AMR_PCT_MAX
    |=> rsp_exception && $stable(position_demand))
    else $error("demand above limit taken");
  demand_store_a: assert property (dem_wr && req_wdata <= `AMR_PCT_MAX
    |=> position_demand == $past(req_wdata))
    else $error("demand not stored");
  diag_pulse_a: assert property (wr_req && req_addr == `AMR_REG_DIAG_RST
    && req_wdata == `AMR_ONE16 |-> ##2 diag_clear_pulse)
    else $error("no diagnostic clear pulse");
  recal_pulse_a: assert property (wr_req && req_addr == `AMR_REG_RECAL
    && req_wdata == `AMR_ONE16 |-> ##2 recal_pulse)
    else $error("no recalibration pulse");
endmodule

//--- verification/amr_register_map_tb.sv
// self-checking bench for the register map
`timescale 1ns/100ps
`include "amr_consts.vh"
module amr_register_map_tb;
  reg ref_clk = 0;
  reg rst = 1;
  reg req_valid = 0;
  reg [7:0] req_func = 0;
  reg [15:0] req_addr = 0, req_wdata = 0, local_demand = 0;
  reg [15:0] fault_flags_in = 0, analog_level = 0, sticky_restore = 16'h0001;
  reg local_source_sel = 0, analog_current_mode = 0, powerup_ok = 0;
  reg restore_load = 0;
  reg [31:0] moves_restore = 32'h0005_0000, powered_restore = 32'h0002_0000;
  reg [31:0] open_restore = 32'h0003_0000, closed_restore = 32'h0004_0000;
  reg [31:0] powerups_restore = 32'h0000_0007;
  wire rsp_valid, rsp_exception, move_done, calibrated;
  wire [7:0] rsp_exc_code;
  wire [15:0] rsp_rdata, position_meas, position_demand;
  wire [15:0] cal_zero_level, cal_full_level;
  reg [15:0] got;
  reg [7:0] ecode;
  integer bad_count, comparisons, i;
  amr_register_map #(.fw_release(16'h0415), .time_tick_cycles(16'h0004))
  i_amr_register_map (.ref_clk, .rst, .req_valid, .req_func, .req_addr,
    .req_wdata, .rsp_valid, .rsp_rdata, .rsp_exception, .rsp_exc_code,
    .position_meas, .local_demand, .local_source_sel, .fault_flags_in,
    .analog_level, .analog_current_mode, .move_done, .powerup_ok,
    .sticky_restore, .moves_restore, .powered_restore, .open_restore,
    .closed_restore, .powerups_restore, .restore_load, .position_demand,
    .applied_demand(), .diag_clear_pulse(), .recal_pulse(), .calibrated,
    .cal_zero_level, .cal_full_level, .sticky_fault_flags(),
    .movement_count(), .powered_time(), .open_time(), .closed_time(),
    .power_on_count());
  amr_plant_model i_amr_plant_model (.ref_clk, .rst, .position_demand,
    .position_meas, .move_done);
  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  task test_done;
  begin
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  task chk16(input [15:0] e, input [15:0] g);
  begin
    comparisons = comparisons + 1;
    if (g !== e)
    begin
      bad_count = bad_count + 1;
      $display("FAIL %0t exp %h got %h", $time, e, g);
    end
  end
  endtask
  task chk8(input [7:0] e, input [7:0] g);
  begin
    comparisons = comparisons + 1;
    if (g !== e)
    begin
      bad_count = bad_count + 1;
      $display("FAIL %0t code exp %h got %h", $time, e, g);
    end
  end
  endtask
  // an idle cycle ahead of each request keeps strobe edges apart
  task op(input [7:0] f, input [15:0] a, input [15:0] d, input [7:0] ec);
  begin
    @(posedge ref_clk);
    #1;
    req_valid = 1;
    req_func = f;
    req_addr = a;
    req_wdata = d;
    @(posedge ref_clk);
    #1;
    req_valid = 0;
    got = rsp_rdata;
    ecode = rsp_exception ? rsp_exc_code : 8'h00;
    chk8(ec, ecode);
    if (rsp_valid !== 1'b1)
    begin
      bad_count = bad_count + 1;
      test_done;
    end
  end
  endtask
  task rd(input [15:0] a, input [15:0] e);
  begin
    op(`AMR_FN_READ, a, 16'h0000, 8'h00);
    chk16(e, got);
  end
  endtask
  initial
  begin
    bad_count = 0;
    comparisons = 0;
    repeat (20) @(posedge ref_clk);
    #1 rst = 0;
    restore_load = 1;
    @(posedge ref_clk);
    #1 restore_load = 0;
    rd(`AMR_REG_DEMAND, 16'h0000);
    rd(`AMR_REG_TEST, `AMR_TEST_PATTERN);
    for (i = 5; i < 8; i = i + 1)
      rd(i[15:0], 16'h0000);
    rd(`AMR_REG_RSVD_D, 16'h0000);
    op(`AMR_FN_WRITE1, `AMR_REG_RSVD_B, 16'h0001, `AMR_EXC_ADDR);
    op(`AMR_FN_WRITEN, `AMR_REG_TEST, 16'h0000, `AMR_EXC_ADDR);
    rd(`AMR_REG_TEST, `AMR_TEST_PATTERN);
    rd(`AMR_REG_RSVD_B, 16'h0000);
    op(`AMR_FN_WRITE1, `AMR_REG_DEMAND, 16'h0032, 8'h00);
    repeat (60) @(posedge ref_clk);
    rd(`AMR_REG_MEAS_POS, 16'h0032);
    op(`AMR_FN_WRITE1, `AMR_REG_DEMAND, 16'h0065, `AMR_EXC_VALUE);
    rd(`AMR_REG_DEMAND, 16'h0032);
    op(`AMR_FN_WRITEN, `AMR_REG_DEMAND, `AMR_PCT_MAX, 8'h00);
    repeat (60) @(posedge ref_clk);
    rd(`AMR_REG_APPLIED, `AMR_PCT_MAX);
    rd(`AMR_REG_MOVES, 16'h0002);
    rd(`AMR_REG_MOVES + 16'h0001, 16'h0005);
    rd(`AMR_REG_POWERED + 16'h0001, 16'h0002);
    rd(`AMR_REG_OPEN + 16'h0001, 16'h0003);
    rd(`AMR_REG_CLOSED + 16'h0001, 16'h0004);
    for (i = 0; i < 2; i = i + 1)
    begin
      @(posedge ref_clk);
      #1 powerup_ok = 1;
      @(posedge ref_clk);
      #1 powerup_ok = 0;
    end
    rd(`AMR_REG_POWERUPS, 16'h0009);
    rd(`AMR_REG_POWERUPS + 16'h0001, 16'h0000);
    local_source_sel = 1;
    local_demand = 16'h001e;
    rd(`AMR_REG_APPLIED, 16'h001e);
    fault_flags_in = 16'h4000;
    rd(`AMR_REG_LIVE, 16'h4000);
    fault_flags_in = 16'h0000;
    rd(`AMR_REG_LIVE, 16'h0000);
    rd(`AMR_REG_STICKY, 16'h4001);
    analog_level = 16'h0005;
    rd(`AMR_REG_ANALOG, 16'h0005);
    op(`AMR_FN_WRITE1, `AMR_REG_CAL_LO, `AMR_ONE16, 8'h00);
    repeat (3) @(posedge ref_clk);
    chk16(16'h0005, cal_zero_level);
    rd(`AMR_REG_CAL_LO, 16'h0000);
    analog_level = 16'h0050;
    rd(`AMR_REG_ANALOG, 16'h0032);
    op(`AMR_FN_WRITE1, `AMR_REG_CAL_HI, `AMR_ONE16, 8'h00);
    repeat (3) @(posedge ref_clk);
    chk16(16'h0032, cal_full_level);
    chk16(16'h0001, {15'h0000, calibrated});
    analog_current_mode = 1;
    rd(`AMR_REG_ANALOG, 16'h0050);
    analog_level = 16'h00d2;
    rd(`AMR_REG_ANALOG, 16'h00c8);
    op(`AMR_FN_WRITE1, `AMR_REG_RECAL, `AMR_ONE16, 8'h00);
    repeat (3) @(posedge ref_clk);
    chk16(16'h0000, {15'h0000, calibrated});
    rd(`AMR_REG_RECAL, 16'h0000);
    op(`AMR_FN_WRITEN, `AMR_REG_DIAG_RST, `AMR_ONE16, 8'h00);
    rd(`AMR_REG_DIAG_RST, 16'h0000);
    op(`AMR_FN_WRITE1, `AMR_REG_DIAG_RST, 16'h0002, 8'h00);
    rd(`AMR_REG_DIAG_RST, 16'h0000);
    rd(`AMR_REG_FW_REL, {8'h04, 8'h15});
    rd(`AMR_REG_FW_PROJ, 16'h0001);
    rd(`AMR_REG_FW_DOC, 16'h0001);
    rd(`AMR_REG_SERIAL, 16'h0001);
    rd(`AMR_REG_SERIAL + 16'h0001, 16'h0000);
    op(8'h05, `AMR_REG_DEMAND, 16'h0000, `AMR_EXC_FUNC);
    op(`AMR_FN_READ, 16'h001e, 16'h0000, `AMR_EXC_ADDR);
    test_done;
  end
endmodule
bind amr_register_map amr_map_sva i_amr_map_sva (.ref_clk, .rst, .req_valid,
  .req_func, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata, .rsp_exception,
  .rsp_exc_code, .position_demand, .diag_clear_pulse, .recal_pulse);
